// ==== core/timer16_core.sv ====
/*
 16-bit timer/counter with byte access through one shared high-byte latch.
 assumes single-cycle io strobes, pins synchronous to pclk, one access/cycle.
*/
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_regs.svh"

// Behaviour
// [RL1] wide registers move as two byte accesses
// [RL2] one shared high-byte holding register
// [RL3] low write loads held high byte too
// [RL4] low read copies high byte to holder
// [RL5] compare high reads bypass the holder
// [RL6] software writes high byte first
// [RL7] software reads low byte first
// [RL8] software masks interrupts around wide access
// [RL9] control registers plain single-access bytes
// [RL10] clock select internal, or pin edge
// [RL11] compares checked against counter every cycle
// [RL12] compare match sets channel flag
// [RL13] flags shared register, individually masked
// [RL14] bottom is counter zero
// [RL15] max is counter all ones
// [RL16] top fixed, compare a or capture
// [RL17] compare a top blocks pwm on a
// [RL18] compare a top is double buffered; in mode 4 the code writes compare a directly, unbuffered
// [RL19] capture latches counter on edge event
// [RL20] force strobes and fourth mode bit
// [RL21] high address reaches the holding register
// [RL22] select zero stops, still accessible
// [RL23] cpu counter write beats count
// [RL24] holder keeps value after writes
module timer16_core
	import timer16_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	timer16_if.timer bus,
	input wire logic presc_tick,
	input wire logic ext_clock_pin,
	input wire logic capture_input_pin,
	input wire logic comparator_out,
	input wire logic capture_from_comparator,
	output logic [1:0] compare_output_pins,
	output logic irq
);
	// ==========================================================
	// registers
	logic [7:0] hold_q; // [RL2]
	logic [15:0] counter_value_q, compare_reg_a_q, compare_reg_b_q, capture_reg_q;
	logic [15:0] cmpa_buf_q, cmpb_buf_q;
	logic [7:0] timer_ctrl_a_q, timer_ctrl_b_q, shared_irq_flags_q, shared_irq_mask_q;
	logic [7:0] rdata_q;
	logic [1:0] out_q;
	logic irq_q;
	logic ext_s1_q, ext_s2_q, ext_s3_q, cap_s1_q, cap_s2_q, cap_s3_q;
	logic [3:0] filt_q;
	logic cap_lvl_q;
	logic up_q;

	// ==========================================================
	// decode
	wire wr_cnt_lo = bus.io_wr && bus.io_addr == `ADR_CNT_LO;
	wire wr_cmpa_lo = bus.io_wr && bus.io_addr == `ADR_CMPA_LO;
	wire wr_cmpb_lo = bus.io_wr && bus.io_addr == `ADR_CMPB_LO;
	wire [3:0] wave_mode = {timer_ctrl_b_q[`CTRLB_WGM3], timer_ctrl_b_q[`CTRLB_WGM2],
		timer_ctrl_a_q[1:0]};
	wire top_is_cap = wave_mode == 4'd8 || wave_mode == 4'd10 || wave_mode == 4'd12
		|| wave_mode == 4'd14;
	wire wr_cap_lo = bus.io_wr && bus.io_addr == `ADR_CAP_LO && top_is_cap;
	wire top_is_cmpa = wave_mode == 4'd4 || wave_mode == 4'd9 || wave_mode == 4'd11
		|| wave_mode == 4'd15;
	wire pwm_mode = wave_mode != 4'd0 && wave_mode != 4'd4 && wave_mode != 4'd12;
	wire dual_slope = wave_mode[3:1] == 3'd0 ? wave_mode[0] :
		(wave_mode == 4'd1 || wave_mode == 4'd2 || wave_mode == 4'd3
		|| wave_mode == 4'd8 || wave_mode == 4'd9 || wave_mode == 4'd10 || wave_mode == 4'd11);
	wire [15:0] wide_wdata = {hold_q, bus.io_wdata}; // [RL3]

	// [RL16] top selection
	wire [15:0] top_val = top_is_cmpa ? compare_reg_a_q :
		top_is_cap ? capture_reg_q :
		(wave_mode[1:0] == 2'd1) ? `TOP_8BIT :
		(wave_mode[1:0] == 2'd2) ? `TOP_9BIT :
		(wave_mode[1:0] == 2'd3) ? `TOP_10BIT : `VAL_MAX;
	wire at_bottom = counter_value_q == `VAL_BOTTOM; // [RL14]
	wire at_max = counter_value_q == `VAL_MAX; // [RL15]
	wire at_top = counter_value_q == top_val;

	// [RL10] [RL22] clock select; zero gives no tick
	wire [2:0] clock_select_field = timer_ctrl_b_q[2:0];
	wire ext_rise = ext_s2_q && !ext_s3_q;
	wire ext_fall = !ext_s2_q && ext_s3_q;
	wire timer_tick = clock_select_field == 3'd1 ? 1'b1 :
		clock_select_field == 3'd6 ? ext_fall :
		clock_select_field == 3'd7 ? ext_rise :
		clock_select_field == 3'd0 ? 1'b0 : presc_tick;

	// [RL11] continuous compare
	wire match_a = counter_value_q == compare_reg_a_q;
	wire match_b = counter_value_q == compare_reg_b_q;
	wire force_a = bus.io_wr && bus.io_addr == `ADR_CTRL_A && bus.io_wdata[`CTRLA_FOCA]
		&& !pwm_mode; // [RL20]
	wire force_b = bus.io_wr && bus.io_addr == `ADR_CTRL_A && bus.io_wdata[`CTRLA_FOCB]
		&& !pwm_mode; // [RL20]

	// [RL19] capture source, optional filter, edge detect
	wire cap_raw = cap_s2_q;
	wire filt_all1 = &filt_q;
	wire filt_all0 = ~|filt_q;
	wire cap_in = timer_ctrl_b_q[`CTRLB_NOISE] ? (filt_all1 ? 1'b1 : filt_all0 ? 1'b0 :
		cap_lvl_q) : cap_raw;
	wire cap_event = !top_is_cap && (cap_in != cap_lvl_q) &&
		(cap_in == timer_ctrl_b_q[`CTRLB_EDGE]);

	// next counter value
	wire [15:0] cnt_step = (dual_slope && !up_q) ? counter_value_q - 16'h0001 :
		counter_value_q + 16'h0001;
	wire [15:0] cnt_run = (!dual_slope && at_top) ? `RST_WORD : cnt_step;
	wire [15:0] cnt_d = wr_cnt_lo ? wide_wdata : (timer_tick ? cnt_run : counter_value_q); // [RL23]
	wire update_buf = pwm_mode ? (dual_slope ? at_bottom : at_top) && timer_tick : 1'b1;
	wire ovf = timer_tick && (dual_slope ? at_bottom && !up_q : (pwm_mode ? at_top : at_max));

	// read mux
	wire [7:0] ctrl_b_rd = timer_ctrl_b_q;
	logic [7:0] rd_mux;
	always_comb
	begin
		case (bus.io_addr)
			`ADR_CNT_LO: rd_mux = counter_value_q[7:0];
			`ADR_CAP_LO: rd_mux = capture_reg_q[7:0];
			`ADR_CNT_HI, `ADR_CAP_HI: rd_mux = hold_q; // [RL21]
			`ADR_CMPA_LO: rd_mux = compare_reg_a_q[7:0];
			`ADR_CMPA_HI: rd_mux = compare_reg_a_q[15:8]; // [RL5]
			`ADR_CMPB_LO: rd_mux = compare_reg_b_q[7:0];
			`ADR_CMPB_HI: rd_mux = compare_reg_b_q[15:8]; // [RL5]
			`ADR_CTRL_A: rd_mux = {timer_ctrl_a_q[7:4], 2'b00, timer_ctrl_a_q[1:0]};
			`ADR_CTRL_B: rd_mux = ctrl_b_rd; // [RL9]
			`ADR_FLAGS: rd_mux = shared_irq_flags_q; // [RL13]
			`ADR_MASK: rd_mux = shared_irq_mask_q;
			default: rd_mux = `RST_BYTE;
		endcase
	end
	wire rd_low = bus.io_rd && (bus.io_addr == `ADR_CNT_LO || bus.io_addr == `ADR_CAP_LO);
	wire [7:0] rd_high = bus.io_addr == `ADR_CNT_LO ? counter_value_q[15:8] : capture_reg_q[15:8];
	wire wr_high = bus.io_wr && (bus.io_addr == `ADR_CNT_HI || bus.io_addr == `ADR_CMPA_HI
		|| bus.io_addr == `ADR_CMPB_HI || bus.io_addr == `ADR_CAP_HI); // [RL21]

	// flags: hardware set wins over write-one-to-clear
	wire [7:0] flag_set = {2'b00, cap_event, match_a && timer_tick || force_a,
		match_b && timer_tick || force_b, ovf, 2'b00}; // [RL12]
	wire [7:0] flag_clr = (bus.io_wr && bus.io_addr == `ADR_FLAGS) ? bus.io_wdata : `RST_BYTE;
	wire [7:0] flags_d = (shared_irq_flags_q & ~flag_clr) | flag_set;

	// [RL17] channel a idle when it defines top in pwm
	wire out_a_d = (pwm_mode && top_is_cmpa) ? 1'b0 :
		(match_a && timer_tick || force_a) ? !out_q[0] && !pwm_mode || (pwm_mode && !up_q) :
		out_q[0];
	// match acts on a tick only: a stopped counter resting on a compare value must not toggle
	wire out_b_d = (match_b && timer_tick || force_b) ?
		!out_q[1] && !pwm_mode || (pwm_mode && !up_q) : out_q[1];
	wire up_d = !dual_slope ? 1'b1 : (timer_tick ? (at_top ? 1'b0 : at_bottom ? 1'b1 : up_q) : up_q);

	// ==========================================================
	// state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hold_q <= `RST_BYTE;
			counter_value_q <= `RST_WORD;
			compare_reg_a_q <= `RST_WORD;
			compare_reg_b_q <= `RST_WORD;
			cmpa_buf_q <= `RST_WORD;
			cmpb_buf_q <= `RST_WORD;
			capture_reg_q <= `RST_WORD;
			timer_ctrl_a_q <= `RST_BYTE;
			timer_ctrl_b_q <= `RST_BYTE;
			shared_irq_flags_q <= `RST_BYTE;
			shared_irq_mask_q <= `RST_BYTE;
			rdata_q <= `RST_BYTE;
			out_q <= 2'b00;
			irq_q <= 1'b0;
			{ext_s1_q, ext_s2_q, ext_s3_q, cap_s1_q, cap_s2_q, cap_s3_q} <= 6'h00;
			filt_q <= 4'h0;
			cap_lvl_q <= 1'b0;
			up_q <= 1'b1;
		end
		else
		begin
			// [RL4] low read snapshot; otherwise high write; holder keeps value [RL24]
			if (rd_low)
				hold_q <= rd_high;
			else if (wr_high)
				hold_q <= bus.io_wdata;
			counter_value_q <= cnt_d;
			if (wr_cmpa_lo)
				cmpa_buf_q <= wide_wdata; // [RL3]
			if (wr_cmpb_lo)
				cmpb_buf_q <= wide_wdata;
			if (update_buf)
				compare_reg_a_q <= wr_cmpa_lo && !pwm_mode ? wide_wdata : cmpa_buf_q; // [RL18]
			if (update_buf)
				compare_reg_b_q <= wr_cmpb_lo && !pwm_mode ? wide_wdata : cmpb_buf_q;
			if (wr_cap_lo)
				capture_reg_q <= wide_wdata;
			else if (cap_event)
				capture_reg_q <= counter_value_q; // [RL19]
			if (bus.io_wr && bus.io_addr == `ADR_CTRL_A)
				timer_ctrl_a_q <= {bus.io_wdata[7:4], 2'b00, bus.io_wdata[1:0]}; // [RL9]
			if (bus.io_wr && bus.io_addr == `ADR_CTRL_B)
				timer_ctrl_b_q <= bus.io_wdata; // [RL9]
			if (bus.io_wr && bus.io_addr == `ADR_MASK)
				shared_irq_mask_q <= bus.io_wdata;
			shared_irq_flags_q <= flags_d;
			irq_q <= |(flags_d & shared_irq_mask_q); // [RL13]
			if (bus.io_rd)
				rdata_q <= rd_mux;
			out_q <= {out_b_d, out_a_d};
			ext_s1_q <= ext_clock_pin;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			cap_s1_q <= capture_from_comparator ? comparator_out : capture_input_pin;
			cap_s2_q <= cap_s1_q;
			cap_s3_q <= cap_s2_q;
			filt_q <= {filt_q[2:0], cap_raw};
			cap_lvl_q <= cap_in;
			up_q <= up_d;
		end
	end

	assign bus.io_rdata = rdata_q;
	assign compare_output_pins = out_q;
	assign irq = irq_q;
endmodule
`default_nettype wire

// ==== shared/timer16_regs.svh ====
/*
 byte-wide register map, field positions, reset values and fixed tops of the
 16-bit timer, plus the controller's own apb register offsets.
 assumes inclusion by bare name; definitions only.
*/
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH

// ==========================================================
// timer byte addresses (6-bit io space)
`define ADR_CNT_LO 6'h2c
`define ADR_CNT_HI 6'h2d
`define ADR_CMPA_LO 6'h2a
`define ADR_CMPA_HI 6'h2b
`define ADR_CMPB_LO 6'h28
`define ADR_CMPB_HI 6'h29
`define ADR_CAP_LO 6'h26
`define ADR_CAP_HI 6'h27
`define ADR_CTRL_A 6'h2f
`define ADR_CTRL_B 6'h2e
`define ADR_FLAGS 6'h38
`define ADR_MASK 6'h39

// ==========================================================
// field positions
`define CTRLA_FOCA 3
`define CTRLA_FOCB 2
`define CTRLB_NOISE 7
`define CTRLB_EDGE 6
`define CTRLB_WGM3 4
`define CTRLB_WGM2 3
`define FLG_CAP 5
`define FLG_CMPA 4
`define FLG_CMPB 3
`define FLG_OVF 2

// ==========================================================
// reset values and limits
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define VAL_BOTTOM 16'h0000
`define VAL_MAX 16'hffff
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff

// ==========================================================
// controller apb offsets
`define APB_CMD 12'h000
`define APB_STATUS 12'h004
`define APB_RDATA 12'h008

`endif

// ==== shared/timer16_pkg.sv ====
/*
 types shared by both ends of the timer register link.
 assumes nothing beyond a systemverilog compiler.
*/
package timer16_pkg;
	typedef enum logic [1:0] {
		ctl_idle = 2'b00,
		ctl_first = 2'b01,
		ctl_second = 2'b11,
		ctl_done = 2'b10
	} ctl_state_t;
	typedef logic [5:0] io_addr_t;
	typedef logic [7:0] io_byte_t;
endpackage

// ==== shared/timer16_if.sv ====
/*
 8-bit io bus between the cpu-side controller and the timer.
 assumes a single clock; read data is valid the cycle after io_rd.
*/
`timescale 1ns/1ps
`default_nettype none
interface timer16_if;
	logic [5:0] io_addr;
	logic [7:0] io_wdata;
	logic io_wr;
	logic io_rd;
	logic [7:0] io_rdata;
	modport timer (input io_addr, io_wdata, io_wr, io_rd, output io_rdata);
	modport cpu (output io_addr, io_wdata, io_wr, io_rd, input io_rdata);
endinterface
`default_nettype wire

// ==== core/timer16_cpu.sv ====
/*
 apb-controlled cpu stand-in that performs byte and wide accesses on the timer bus.
 assumes the timer answers reads one cycle after io_rd.
*/
`timescale 1ns/1ps
`default_nettype none
`include "timer16_regs.svh"
module timer16_cpu
	import timer16_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	timer16_if.cpu bus
);
	// cmd word: [31] wide, [30] write, [21:16] low addr, [15:0] data
	ctl_state_t state_q, state_d;
	logic [31:0] cmd_q, prdata_q;
	logic [15:0] rdata_q;
	logic [5:0] addr_q;
	logic [7:0] wdata_q;
	logic wr_q, rd_q, busy_q, pready_q, pslverr_q;

	wire access = psel && penable && !pready_q;
	// a command lands only at the edge that completes the transfer, with pready high
	wire cmd_wr = psel && penable && pready_q && pwrite && paddr == `APB_CMD && !busy_q;
	wire known = paddr == `APB_CMD || paddr == `APB_STATUS || paddr == `APB_RDATA;
	wire is_wide = cmd_q[31];
	wire is_write = cmd_q[30];
	wire [5:0] lo_addr = cmd_q[21:16];
	wire [5:0] hi_addr = lo_addr + 6'h01;
	wire [31:0] rd_sel = paddr == `APB_STATUS ? {31'h0, busy_q} :
		paddr == `APB_RDATA ? {16'h0, rdata_q} : cmd_q;

	// [RL1] wide access is two byte steps; [RL6] write high first; [RL7] read low first
	always_comb
	begin
		case (state_q)
			ctl_idle: state_d = cmd_wr ? ctl_first : ctl_idle;
			ctl_first: state_d = is_wide ? ctl_second : ctl_done;
			ctl_second: state_d = ctl_done;
			ctl_done: state_d = ctl_idle;
			default: state_d = ctl_idle;
		endcase
	end

	// ==========================================================
	// sequencing; [RL8] a wide pair is never split by another access here
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= ctl_idle;
			cmd_q <= 32'h0000_0000;
			rdata_q <= 16'h0000;
			addr_q <= 6'h00;
			wdata_q <= 8'h00;
			{wr_q, rd_q, busy_q, pready_q, pslverr_q} <= 5'h00;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			state_q <= state_d;
			pready_q <= access;
			pslverr_q <= access && !known;
			if (access && !pwrite)
				prdata_q <= rd_sel;
			if (cmd_wr)
				cmd_q <= pwdata;
			busy_q <= cmd_wr || (state_d != ctl_idle);
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			case (state_d)
				ctl_first:
				begin
					wr_q <= pwdata[30];
					rd_q <= !pwdata[30];
					addr_q <= (pwdata[31] && pwdata[30]) ? pwdata[21:16] + 6'h01 : pwdata[21:16];
					wdata_q <= (pwdata[31] && pwdata[30]) ? pwdata[15:8] : pwdata[7:0];
				end
				ctl_second:
				begin
					wr_q <= is_write;
					rd_q <= !is_write;
					addr_q <= is_write ? lo_addr : hi_addr;
					wdata_q <= cmd_q[7:0];
				end
				default:
				begin
					addr_q <= addr_q;
				end
			endcase
			if (state_q == ctl_second && !is_write)
				rdata_q[7:0] <= bus.io_rdata;
			if (state_q == ctl_done && !is_write)
			begin
				if (is_wide)
					rdata_q[15:8] <= bus.io_rdata;
				else
					rdata_q <= {8'h00, bus.io_rdata};
			end
		end
	end

	assign bus.io_addr = addr_q;
	assign bus.io_wdata = wdata_q;
	assign bus.io_wr = wr_q;
	assign bus.io_rd = rd_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule
`default_nettype wire

// ==== tb/timer16_properties.sv ====
/*
 io bus properties of the timer register link.
 assumes one clock and compare registers in non-pwm modes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "timer16_regs.svh"
module timer16_properties
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_rdata
);
// ==========
// shadow of holder and compares
logic [7:0] hold_q;
logic [7:0] exp_q;
logic [15:0] cmpa_q;
logic [15:0] cmpb_q;
logic ok_q;
logic cmp_q;
logic cmp_hi_q;
logic hrd_q;
wire wide_hi = io_addr inside {`ADR_CNT_HI, `ADR_CMPA_HI, `ADR_CMPB_HI, `ADR_CAP_HI};
wire wide_lo = io_addr inside {`ADR_CNT_LO, `ADR_CMPA_LO, `ADR_CMPB_LO, `ADR_CAP_LO};
wire hold_lo = io_rd && (io_addr == `ADR_CNT_LO || io_addr == `ADR_CAP_LO);
wire hold_rd = io_rd && (io_addr == `ADR_CNT_HI || io_addr == `ADR_CAP_HI);
wire cmp_rd = io_rd && io_addr[5:2] == 4'ha;
wire [7:0] cmpa_byte = io_addr[0] ? cmpa_q[15:8] : cmpa_q[7:0];
wire [7:0] cmpb_byte = io_addr[0] ? cmpb_q[15:8] : cmpb_q[7:0];
wire [7:0] cmp_byte = io_addr[1] ? cmpa_byte : cmpb_byte;
// holder content is unknown here once a counter or capture low read copied into it
always_ff @(posedge pclk or negedge presetn)
	if (!presetn)
	begin
		hold_q <= 8'h00;
		ok_q <= 1'h0;
	end
	else if (io_wr && wide_hi)
	begin
		hold_q <= io_wdata;
		ok_q <= 1'h1;
	end
	else if (hold_lo)
		ok_q <= 1'h0;
always_ff @(posedge pclk or negedge presetn)
	if (!presetn)
		cmpa_q <= 16'h0000;
	else if (io_wr && io_addr == `ADR_CMPA_LO)
		cmpa_q <= {hold_q, io_wdata};
always_ff @(posedge pclk or negedge presetn)
	if (!presetn)
		cmpb_q <= 16'h0000;
	else if (io_wr && io_addr == `ADR_CMPB_LO)
		cmpb_q <= {hold_q, io_wdata};
always_ff @(posedge pclk or negedge presetn)
	if (!presetn)
	begin
		cmp_q <= 1'h0;
		cmp_hi_q <= 1'h0;
		hrd_q <= 1'h0;
		exp_q <= 8'h00;
	end
	else
	begin
		cmp_q <= cmp_rd;
		cmp_hi_q <= io_addr[0];
		hrd_q <= hold_rd && ok_q;
		exp_q <= cmp_rd ? cmp_byte : hold_q;
	end
// ==========
// properties
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
sequence s_wr_pair; io_wr ##1 io_wr; endsequence
sequence s_rd_pair; io_rd ##1 io_rd; endsequence
property p_excl; !(io_wr && io_rd); endproperty
property p_wr_order; s_wr_pair |-> $past(wide_hi) && io_addr == $past(io_addr) - 6'h01; endproperty
property p_rd_order; s_rd_pair |-> $past(wide_lo) && io_addr == $past(io_addr) + 6'h01; endproperty
property p_wr_len; s_wr_pair |=> !io_wr; endproperty
property p_rd_len; s_rd_pair |=> !io_rd; endproperty
property p_cmp_lo; cmp_q && !cmp_hi_q |-> io_rdata == exp_q; endproperty
property p_cmp_hi; cmp_q && cmp_hi_q |-> io_rdata == exp_q; endproperty
property p_hold; hrd_q |-> io_rdata == exp_q; endproperty
a_excl: assert property (p_excl)
	else $error("read and write strobes together");
a_wr_order: assert property (p_wr_order)
	else $error("wide write not high then low");
a_rd_order: assert property (p_rd_order)
	else $error("wide read not low then high");
a_wr_len: assert property (p_wr_len)
	else $error("more than two write strobes in a row");
a_rd_len: assert property (p_rd_len)
	else $error("more than two read strobes in a row");
a_cmp_lo: assert property (p_cmp_lo)
	else $error("compare low byte differs from held plus written");
a_cmp_hi: assert property (p_cmp_hi)
	else $error("compare high byte not read directly");
a_hold: assert property (p_hold)
	else $error("high address read did not return holder");
endmodule
`default_nettype wire

// ==== tb/sixteen_bit_timer_register_access_tb_top.sv ====
/*
 bench for the timer register link: apb stimulus, queued read checks.
 assumes both design ends and the properties checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "timer16_regs.svh"
module sixteen_bit_timer_register_access_tb_top
	import timer16_pkg::*;
;
logic pclk = 1'h0;
logic presetn, psel, penable, pwrite, pready, pslverr, irq;
logic presc_tick, ext_clock_pin, comparator_out;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, r;
logic [31:0] lfsr_q = 32'h9e1b;
logic [1:0] compare_output_pins;
logic [32:0] eq[$];
logic [32:0] mq[$];
logic [15:0] v;
int fails = 0;
int checked = 0;
timer16_if bus_if ();
timer16_cpu u_timer16_cpu (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .bus(bus_if));
timer16_core u_timer16_core (.pclk(pclk), .presetn(presetn), .bus(bus_if),
	.presc_tick(presc_tick), .ext_clock_pin(ext_clock_pin), .capture_input_pin(1'h0),
	.comparator_out(comparator_out), .capture_from_comparator(1'h0),
	.compare_output_pins(compare_output_pins), .irq(irq));
timer16_properties u_timer16_properties (.pclk(pclk), .presetn(presetn),
	.io_addr(bus_if.io_addr), .io_wdata(bus_if.io_wdata), .io_wr(bus_if.io_wr),
	.io_rd(bus_if.io_rd), .io_rdata(bus_if.io_rdata));
always #5 pclk = ~pclk;
// ==========
// random pins and checking
function automatic logic [31:0] lfsr(input logic [31:0] s);
	return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
always @(posedge pclk)
begin
	lfsr_q <= lfsr(lfsr_q);
	presc_tick <= lfsr_q[3];
	ext_clock_pin <= lfsr_q[7];
	comparator_out <= lfsr_q[11];
end
task automatic conclude();
	if (fails == 0 && checked > 0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
endtask
task automatic check(input logic [32:0] seen, input logic [32:0] exp);
	checked++;
	if (seen !== exp)
	begin
		fails++;
		$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
	end
endtask
// status polls carry no note, so they are skipped here
always @(posedge pclk)
	if (psel && penable && pready && !pwrite && paddr != `APB_STATUS && eq.size() > 0)
	begin
		check({pslverr, prdata} & mq[0], eq[0]);
		void'(eq.pop_front());
		void'(mq.pop_front());
	end
// ==========
// bus tasks
task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
	output logic [31:0] q);
	@(posedge pclk);
	psel <= 1'h1;
	penable <= 1'h0;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1'h1;
	@(posedge pclk iff pready);
	q = prdata;
	psel <= 1'h0;
	penable <= 1'h0;
endtask
task automatic cmd(input logic wide, input logic wr, input io_addr_t a, input logic [15:0] d);
	apb(1'h1, `APB_CMD, {wide, wr, 8'h00, a, d}, r);
	r = 32'h1;
	while (r[0] !== 1'h0)
		apb(1'h0, `APB_STATUS, 32'h0, r);
endtask
task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
	eq.push_back(e & m);
	mq.push_back(m);
	apb(1'h0, a, 32'h0, r);
endtask
task automatic wrd(input io_addr_t a, input logic [15:0] e);
	cmd(1'h1, 1'h0, a, 16'h0000);
	rd(`APB_RDATA, {17'h0, e}, {1'h1, 16'h0, 16'hffff});
endtask
task automatic brd(input io_addr_t a, input logic [7:0] e, input logic [7:0] m);
	cmd(1'h0, 1'h0, a, 16'h0000);
	rd(`APB_RDATA, {25'h0, e}, {1'h1, 24'h0, m});
endtask
// ==========
// scenarios
initial
begin
	presetn = 1'h0;
	{psel, penable, pwrite} = 3'h0;
	paddr = 12'h000;
	pwdata = 32'h0;
	repeat (3) @(posedge pclk);
	presetn <= 1'h1;
	brd(`ADR_FLAGS, 8'h00, 8'h3c);
	repeat (2)
	begin
		v = lfsr_q[15:0];
		cmd(1'h1, 1'h1, `ADR_CNT_LO, v);
		wrd(`ADR_CNT_LO, v);
	end
	v = lfsr_q[31:16];
	cmd(1'h1, 1'h1, `ADR_CNT_LO, v);
	cmd(1'h0, 1'h1, `ADR_CNT_HI, {8'h00, ~v[15:8]});
	wrd(`ADR_CNT_LO, v);
	brd(`ADR_CNT_HI, v[15:8], 8'hff);
	v = lfsr_q[15:0];
	cmd(1'h1, 1'h1, `ADR_CMPA_LO, v);
	cmd(1'h0, 1'h1, `ADR_CAP_HI, {8'h00, ~v[15:8]});
	wrd(`ADR_CMPA_LO, v);
	brd(`ADR_CNT_HI, ~v[15:8], 8'hff);
	cmd(1'h0, 1'h1, `ADR_CMPB_LO, {8'h00, v[7:0] ^ 8'h5a});
	wrd(`ADR_CMPB_LO, {~v[15:8], v[7:0] ^ 8'h5a});
	cmd(1'h0, 1'h1, `ADR_MASK, 16'h0018);
	brd(`ADR_MASK, 8'h18, 8'hff);
	cmd(1'h0, 1'h1, `ADR_CTRL_B, 16'h00c0);
	brd(`ADR_CTRL_B, 8'hc0, 8'hff);
	cmd(1'h1, 1'h1, `ADR_CMPA_LO, 16'h0010);
	cmd(1'h1, 1'h1, `ADR_CMPB_LO, 16'h0020);
	cmd(1'h1, 1'h1, `ADR_CNT_LO, 16'h0000);
	cmd(1'h0, 1'h1, `ADR_CTRL_B, 16'h0001);
	repeat (100) @(posedge pclk);
	// counter ran once through both compare values: each channel toggled once
	check(compare_output_pins, 2'b11);
	check(irq, 1'h1);
	brd(`ADR_FLAGS, 8'h18, 8'h1c);
	cmd(1'h0, 1'h1, `ADR_FLAGS, 16'h0018);
	brd(`ADR_FLAGS, 8'h00, 8'h18);
	check(irq, 1'h0);
	cmd(1'h0, 1'h1, `ADR_CTRL_B, 16'h0000);
	v = lfsr_q[23:8];
	cmd(1'h1, 1'h1, `ADR_CNT_LO, v);
	repeat (20) @(posedge pclk);
	wrd(`ADR_CNT_LO, v);
	rd(12'hffc, {1'h1, 32'h0}, {1'h1, 32'h0});
	@(posedge pclk);
	// every noted read must have been answered and compared
	check(eq.size(), 0);
	conclude();
end
initial
begin
	repeat (5000) @(posedge pclk);
	fails++;
	conclude();
end
endmodule
`default_nettype wire
